// ==== sbt_tap.sv ====
// Boundary-scan test access port of the SRAM
// =========================================================
`default_nettype none

module sbt_tap #(
    // Arbitrary identification value; bit 0 must stay 1
    parameter logic [sbt_pkg::ID_W-1:0] ID_CODE = 32'h0ABC_DEF1
) (
    // System clock and reset
    input  wire logic                      clock,
    input  wire logic                      reset,
    // I/O ring levels
    input  wire logic [sbt_pkg::BSR_W-1:0] ring_pins,
    // Test port
    input  wire logic                      tck,
    input  wire logic                      tms,
    input  wire logic                      tdi,
    output logic                           tdo,
    output logic                           tdo_oe_n
);

    // =========================================================
    // Power-up hold of the test domain
    logic       por, next_por;
    logic [1:0] rst_sync;
    logic       tck_rst;

    always_comb begin
        next_por = reset;
    end

    always_ff @(posedge clock) begin
        por <= next_por;
    end

    // Asserts at once, releases on test clock edges; test clock may be idle at power-up
    always_ff @(posedge tck or posedge por) begin
        if (por) begin
            rst_sync <= sbt_pkg::RST_SYNC_SET;
        end else begin
            rst_sync <= {rst_sync[0], 1'b0};
        end
    end

    assign tck_rst = rst_sync[1];

    // =========================================================
    // Ring snapshot crossing
    sbt_ring_if ring ();

    assign ring.tck     = tck;
    assign ring.tck_rst = tck_rst;

    sbt_ring_xfer u_xfer (
        .clock     (clock),
        .reset     (reset),
        .ring_pins (ring_pins),
        .ring      (ring.src)
    );

    // =========================================================
    // Controller
    function automatic sbt_pkg::sbt_state_t tap_next(input sbt_pkg::sbt_state_t s, input logic m);
        sbt_pkg::sbt_state_t n;
        n = s;
        case (s)
            sbt_pkg::ST_RESET:    n = m ? sbt_pkg::ST_RESET   : sbt_pkg::ST_IDLE;
            sbt_pkg::ST_IDLE:     n = m ? sbt_pkg::ST_SEL_DR  : sbt_pkg::ST_IDLE;
            sbt_pkg::ST_SEL_DR:   n = m ? sbt_pkg::ST_SEL_IR  : sbt_pkg::ST_CAP_DR;
            sbt_pkg::ST_CAP_DR:   n = m ? sbt_pkg::ST_EXIT1_DR : sbt_pkg::ST_SHIFT_DR;
            sbt_pkg::ST_SHIFT_DR: n = m ? sbt_pkg::ST_EXIT1_DR : sbt_pkg::ST_SHIFT_DR;
            sbt_pkg::ST_EXIT1_DR: n = m ? sbt_pkg::ST_UPD_DR  : sbt_pkg::ST_PAUSE_DR;
            sbt_pkg::ST_PAUSE_DR: n = m ? sbt_pkg::ST_EXIT2_DR : sbt_pkg::ST_PAUSE_DR;
            sbt_pkg::ST_EXIT2_DR: n = m ? sbt_pkg::ST_UPD_DR  : sbt_pkg::ST_SHIFT_DR;
            sbt_pkg::ST_UPD_DR:   n = m ? sbt_pkg::ST_SEL_DR  : sbt_pkg::ST_IDLE;
            sbt_pkg::ST_SEL_IR:   n = m ? sbt_pkg::ST_RESET   : sbt_pkg::ST_CAP_IR;
            sbt_pkg::ST_CAP_IR:   n = m ? sbt_pkg::ST_EXIT1_IR : sbt_pkg::ST_SHIFT_IR;
            sbt_pkg::ST_SHIFT_IR: n = m ? sbt_pkg::ST_EXIT1_IR : sbt_pkg::ST_SHIFT_IR;
            sbt_pkg::ST_EXIT1_IR: n = m ? sbt_pkg::ST_UPD_IR  : sbt_pkg::ST_PAUSE_IR;
            sbt_pkg::ST_PAUSE_IR: n = m ? sbt_pkg::ST_EXIT2_IR : sbt_pkg::ST_PAUSE_IR;
            sbt_pkg::ST_EXIT2_IR: n = m ? sbt_pkg::ST_UPD_IR  : sbt_pkg::ST_SHIFT_IR;
            sbt_pkg::ST_UPD_IR:   n = m ? sbt_pkg::ST_SEL_DR  : sbt_pkg::ST_IDLE;
            default:              n = sbt_pkg::ST_RESET;
        endcase
        return n;
    endfunction

    sbt_pkg::sbt_state_t             state, next_state;
    logic [sbt_pkg::IR_W-1:0]        ir, next_ir, ir_sh, next_ir_sh;
    logic                            bypass, next_bypass;
    logic [sbt_pkg::ID_W-1:0]        id_sh, next_id_sh;
    logic [sbt_pkg::BSR_W-1:0]       bsr, next_bsr;
    logic                            sel_id, sel_bsr;

    // Unsupported codes fall through to bypass
    assign sel_id  = (ir == sbt_pkg::OP_IDCODE);
    assign sel_bsr = (ir == sbt_pkg::OP_SAMPLE);

    always_comb begin
        next_state  = tap_next(state, tms);
        next_ir     = ir;
        next_ir_sh  = ir_sh;
        next_bypass = bypass;
        next_id_sh  = id_sh;
        next_bsr    = bsr;
        case (state)
            sbt_pkg::ST_RESET: begin
                next_ir = sbt_pkg::OP_IDCODE;
            end
            sbt_pkg::ST_CAP_IR: begin
                next_ir_sh = sbt_pkg::IR_CAPTURE;
            end
            sbt_pkg::ST_SHIFT_IR: begin
                next_ir_sh = {tdi, ir_sh[sbt_pkg::IR_W-1:1]};
            end
            sbt_pkg::ST_UPD_IR: begin
                next_ir = ir_sh;
            end
            sbt_pkg::ST_CAP_DR: begin
                next_bypass = 1'b0;
                if (sel_id) begin
                    next_id_sh = ID_CODE;
                end else if (sel_bsr) begin
                    next_bsr = ring.word;
                end
            end
            sbt_pkg::ST_SHIFT_DR: begin
                if (sel_id) begin
                    next_id_sh = {tdi, id_sh[sbt_pkg::ID_W-1:1]};
                end else if (sel_bsr) begin
                    next_bsr = {tdi, bsr[sbt_pkg::BSR_W-1:1]};
                end else begin
                    next_bypass = tdi;
                end
            end
            default: begin
            end
        endcase
    end

    always_ff @(posedge tck or posedge tck_rst) begin
        if (tck_rst) begin
            state  <= sbt_pkg::ST_RESET;
            ir     <= sbt_pkg::OP_IDCODE;
            ir_sh  <= sbt_pkg::IR_CAPTURE;
            bypass <= 1'b0;
            id_sh  <= ID_CODE;
            bsr    <= sbt_pkg::BSR_RESET;
        end else begin
            state  <= next_state;
            ir     <= next_ir;
            ir_sh  <= next_ir_sh;
            bypass <= next_bypass;
            id_sh  <= next_id_sh;
            bsr    <= next_bsr;
        end
    end

    // =========================================================
    // Serial output on the falling edge
    logic next_tdo, next_tdo_oe_n;

    always_comb begin
        next_tdo      = 1'b0;
        next_tdo_oe_n = 1'b1;
        if (state == sbt_pkg::ST_SHIFT_IR) begin
            next_tdo      = ir_sh[0];
            next_tdo_oe_n = 1'b0;
        end else if (state == sbt_pkg::ST_SHIFT_DR) begin
            next_tdo_oe_n = 1'b0;
            if (sel_id) begin
                next_tdo = id_sh[0];
            end else if (sel_bsr) begin
                next_tdo = bsr[0];
            end else begin
                next_tdo = bypass;
            end
        end
    end

    // Half a test clock of margin for the far end, which samples on the rising edge
    always_ff @(negedge tck or posedge tck_rst) begin
        if (tck_rst) begin
            tdo      <= 1'b0;
            tdo_oe_n <= 1'b1;
        end else begin
            tdo      <= next_tdo;
            tdo_oe_n <= next_tdo_oe_n;
        end
    end

    // =========================================================
    // Assertions
    property p_tms_reset;
        @(posedge tck) disable iff (tck_rst) tms [*5] |=> state == sbt_pkg::ST_RESET;
    endproperty
    a_tms_reset: assert property (p_tms_reset) else $error("five tms highs did not reset");

    property p_ir_preload;
        @(posedge tck) disable iff (tck_rst) state == sbt_pkg::ST_RESET |=> ir == sbt_pkg::OP_IDCODE;
    endproperty
    a_ir_preload: assert property (p_ir_preload) else $error("ir not preloaded in reset");

    property p_walk;
        @(posedge tck) disable iff (tck_rst)
            (state == sbt_pkg::ST_SEL_DR && tms) |=> state == sbt_pkg::ST_SEL_IR;
    endproperty
    a_walk: assert property (p_walk) else $error("bad transition from select-dr");

    property p_oe;
        @(posedge tck) disable iff (tck_rst)
            tdo_oe_n == !(state == sbt_pkg::ST_SHIFT_DR || state == sbt_pkg::ST_SHIFT_IR);
    endproperty
    a_oe: assert property (p_oe) else $error("tdo enable outside shift states");

    property p_bypass_path;
        @(posedge tck) disable iff (tck_rst)
            (state == sbt_pkg::ST_SHIFT_DR && !sel_id && !sel_bsr) ##1 state == sbt_pkg::ST_SHIFT_DR
            |-> tdo == $past(tdi);
    endproperty
    a_bypass_path: assert property (p_bypass_path) else $error("bypass delay wrong");

    property p_unsupported;
        @(posedge tck) disable iff (tck_rst)
            (state == sbt_pkg::ST_SHIFT_DR && ir != sbt_pkg::OP_IDCODE && ir != sbt_pkg::OP_SAMPLE)
            |=> bypass == $past(tdi);
    endproperty
    a_unsupported: assert property (p_unsupported) else $error("unsupported code not bypassed");

    property p_id_capture;
        @(posedge tck) disable iff (tck_rst)
            (state == sbt_pkg::ST_CAP_DR && sel_id) |=> id_sh == ID_CODE;
    endproperty
    a_id_capture: assert property (p_id_capture) else $error("id not captured");

    property p_bsr_capture;
        @(posedge tck) disable iff (tck_rst)
            (state == sbt_pkg::ST_CAP_DR && sel_bsr) |=> bsr == $past(ring.word);
    endproperty
    a_bsr_capture: assert property (p_bsr_capture) else $error("ring not captured");

    property p_ir_out;
        @(posedge tck) disable iff (tck_rst)
            state == sbt_pkg::ST_SHIFT_IR ##1 state == sbt_pkg::ST_SHIFT_IR |-> tdo == $past(ir_sh[1]);
    endproperty
    a_ir_out: assert property (p_ir_out) else $error("ir shifter not on tdo");

    property p_tdo_hold;
        @(posedge tck) disable iff (tck_rst) ##1 $stable(state) |-> $stable(tdo_oe_n);
    endproperty
    a_tdo_hold: assert property (p_tdo_hold) else $error("tdo enable moved without state change");

    property p_por;
        @(posedge clock) reset |=> ##2 (tck_rst && state == sbt_pkg::ST_RESET);
    endproperty
    a_por: assert property (p_por) else $error("power-up did not hold controller");

    c_idcode: cover property (@(posedge tck) disable iff (tck_rst)
        state == sbt_pkg::ST_SHIFT_DR && sel_id);
    c_sample: cover property (@(posedge tck) disable iff (tck_rst)
        state == sbt_pkg::ST_SHIFT_DR && sel_bsr);
    c_ir_update: cover property (@(posedge tck) disable iff (tck_rst)
        state == sbt_pkg::ST_UPD_IR);

endmodule

`default_nettype wire

// ==== sbt_pkg.sv ====
// Constants and types shared by the SRAM boundary-scan test port
`default_nettype none

package sbt_pkg;

    // =========================================================
    // Register sizes
    localparam int unsigned IR_W  = 3;
    localparam int unsigned ID_W  = 32;
    localparam int unsigned BSR_W = 109;

    // =========================================================
    // Instruction codes (limited set; all others act as bypass)
    localparam logic [IR_W-1:0] OP_SAMPLE = 3'h4;
    localparam logic [IR_W-1:0] OP_IDCODE = 3'h1;
    localparam logic [IR_W-1:0] OP_BYPASS = 3'h7;

    // Fixed pattern loaded into the instruction shifter in Capture-IR
    localparam logic [IR_W-1:0] IR_CAPTURE = 3'h1;

    // =========================================================
    // Reset values
    localparam logic [1:0]       RST_SYNC_SET = 2'h3;
    localparam logic [BSR_W-1:0] BSR_RESET    = 109'h0;

    // =========================================================
    // Controller states
    typedef enum logic [3:0] {
        ST_RESET, ST_IDLE,
        ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR, ST_PAUSE_DR, ST_EXIT2_DR, ST_UPD_DR,
        ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR, ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
    } sbt_state_t;

endpackage

`default_nettype wire

// ==== sbt_ring_if.sv ====
// Carrier for the I/O ring snapshot passed into the test clock domain
`default_nettype none

interface sbt_ring_if;
    logic                         tck;
    logic                         tck_rst;
    logic [sbt_pkg::BSR_W-1:0]    word;

    modport src (input tck, input tck_rst, output word);
    modport dst (output tck, output tck_rst, input word);
endinterface

`default_nettype wire

// ==== sbt_ring_xfer.sv ====
// Samples the I/O ring on the system clock and hands it to the test clock domain
`default_nettype none

module sbt_ring_xfer (
    // System side
    input  wire logic                      clock,
    input  wire logic                      reset,
    input  wire logic [sbt_pkg::BSR_W-1:0] ring_pins,
    // Test clock side
    sbt_ring_if.src                        ring
);

    // =========================================================
    // System domain: pin synchroniser, snapshot, request toggle
    logic [sbt_pkg::BSR_W-1:0] ring_s1, ring_s2, snap;
    logic [sbt_pkg::BSR_W-1:0] next_snap;
    logic                      req, next_req;
    logic                      ack_s1, ack_s2;
    logic                      ack;

    // Snapshot is only reloaded once the last one was taken, so it is stable while read
    always_comb begin
        next_snap = snap;
        next_req  = req;
        if (ack_s2 == req) begin
            next_snap = ring_s2;
            next_req  = ~req;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            ring_s1 <= sbt_pkg::BSR_RESET;
            ring_s2 <= sbt_pkg::BSR_RESET;
            snap    <= sbt_pkg::BSR_RESET;
            req     <= 1'b0;
            ack_s1  <= 1'b0;
            ack_s2  <= 1'b0;
        end else begin
            ring_s1 <= ring_pins;
            ring_s2 <= ring_s1;
            snap    <= next_snap;
            req     <= next_req;
            ack_s1  <= ack;
            ack_s2  <= ack_s1;
        end
    end

    // =========================================================
    // Test clock domain: take the word when the request toggles
    logic                      req_s1, req_s2;
    logic                      next_ack;
    logic [sbt_pkg::BSR_W-1:0] word, next_word;

    always_comb begin
        next_ack  = ack;
        next_word = word;
        if (req_s2 != ack) begin
            next_word = snap;
            next_ack  = req_s2;
        end
    end

    always_ff @(posedge ring.tck or posedge ring.tck_rst) begin
        if (ring.tck_rst) begin
            req_s1 <= 1'b0;
            req_s2 <= 1'b0;
            ack    <= 1'b0;
            word   <= sbt_pkg::BSR_RESET;
        end else begin
            req_s1 <= req;
            req_s2 <= req_s1;
            ack    <= next_ack;
            word   <= next_word;
        end
    end

    assign ring.word = word;

endmodule

`default_nettype wire

// ==== sbt_scan_ctl.sv ====
// Behavioural model of the external scan controller driving the test port
`default_nettype none

module sbt_scan_ctl (
    // Test port, driven by this model
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    // Serial return path from the device
    input  wire logic tdo,
    input  wire logic tdo_oe_n
);
    timeunit 1ns;
    timeprecision 100ps;

    // Last level seen while driven; a released line reads its inverse
    logic last = 1'b0;

    // =========================================================
    // Single test clock period, 30 ns; the clock rests low between calls
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end

    task automatic step(input logic m, input logic d, output logic o, output logic oe_n);
        tms = m;
        tdi = d;
        #14;
        o = tdo_oe_n ? ~last : tdo;
        if (!tdo_oe_n) last = tdo;
        oe_n = tdo_oe_n;
        tck = 1'b1;
        #15;
        tck = 1'b0;
        #1;
    endtask

    // Repeats one mode select level; five highs reset the controller from any state
    task automatic run(input logic m, input int k);
        logic o;
        logic e;
        repeat (k) step(m, 1'b0, o, e);
    endtask

    // =========================================================
    // Full scan from Idle back to Idle, LSB first, tdi entering behind
    task automatic scan(input logic ir, input int n, input logic [127:0] din,
                        output logic [127:0] dout, output logic oe_bad);
        logic o;
        logic e;
        dout = '0;
        step(1'b1, 1'b0, o, e);
        if (ir) step(1'b1, 1'b0, o, e);
        step(1'b0, 1'b0, o, e);
        step(1'b0, 1'b0, o, e);
        oe_bad = ~e;
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], o, e);
            dout[i] = o;
            oe_bad |= e;
        end
        step(1'b1, 1'b0, o, e);
        oe_bad |= ~e;
        step(1'b0, 1'b0, o, e);
    endtask
endmodule

`default_nettype wire

// ==== test_sram_boundary_scan_tap.sv ====
// Self-checking bench for the SRAM boundary-scan test port
`default_nettype none

module test_sram_boundary_scan_tap;
    timeunit 1ns;
    timeprecision 100ps;

    // Arbitrary identification value, bit 0 set
    localparam logic [31:0]  ID    = 32'h5EED_0F0F;
    localparam logic [127:0] DIN   = 128'h9E37_79B9_7F4A_7C15_F39C_C060_5CED_C835;
    localparam int           LIMIT = 20000;

    typedef struct {
        logic [2:0] op;
        int         len;
    } sbt_row_t;

    logic                      clock;
    logic                      reset;
    logic [sbt_pkg::BSR_W-1:0] ring_pins;
    logic                      tck;
    logic                      tms;
    logic                      tdi;
    logic                      tdo;
    logic                      tdo_oe_n;
    int                        bad_count = 0;
    int                        cmp_count = 0;
    int                        cycles    = 0;

    // Every code once; sample twice so a stale ring copy shows
    sbt_row_t rows [9] = '{'{3'h0, 1}, '{sbt_pkg::OP_IDCODE, 32}, '{3'h2, 1}, '{3'h3, 1},
                           '{sbt_pkg::OP_SAMPLE, 109}, '{3'h5, 1}, '{3'h6, 1},
                           '{sbt_pkg::OP_BYPASS, 1}, '{sbt_pkg::OP_SAMPLE, 109}};

    sbt_tap #(.ID_CODE(ID)) dut (
        .clock    (clock),
        .reset    (reset),
        .ring_pins(ring_pins),
        .tck      (tck),
        .tms      (tms),
        .tdi      (tdi),
        .tdo      (tdo),
        .tdo_oe_n (tdo_oe_n)
    );

    sbt_scan_ctl ctl (
        .tck     (tck),
        .tms     (tms),
        .tdi     (tdi),
        .tdo     (tdo),
        .tdo_oe_n(tdo_oe_n)
    );

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    // =========================================================
    // Checking and closing
    task automatic check(input logic [127:0] got, input logic [127:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("compares=%0d mismatches=%0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    always @(posedge clock) begin
        cycles++;
        if (cycles == LIMIT) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, cycles, LIMIT);
            tally_and_finish();
        end
    end

    // Serial out may move only while the test clock rests low
    always @(tdo or tdo_oe_n) begin
        if ($time > 0) check(128'(tck), 128'h0);
    end

    // =========================================================
    // Scan helpers; data scans run 11 bits past the register to prove its length
    task automatic load_ir(input logic [2:0] op);
        logic [127:0] got;
        logic         oe_bad;
        ctl.scan(1'b1, sbt_pkg::IR_W, 128'(op), got, oe_bad);
        check(got, 128'(sbt_pkg::IR_CAPTURE));
        check(128'(oe_bad), 128'h0);
    endtask

    task automatic read_dr(input int len, input logic [127:0] cap);
        logic [127:0] got;
        logic         oe_bad;
        ctl.scan(1'b0, len + 11, DIN, got, oe_bad);
        check(got, ((DIN << len) | cap) & ((128'h1 << (len + 11)) - 128'h1));
        check(128'(oe_bad), 128'h0);
    endtask

    // =========================================================
    // Main sequence
    initial begin
        logic [111:0] rv;
        logic [127:0] cap;
        logic         so;
        logic         se;
        reset = 1'b1;
        ring_pins = '0;
        repeat (6) @(posedge clock);
        #1 reset = 1'b0;
        ctl.run(1'b1, 5);
        ctl.run(1'b0, 1);
        for (int i = 0; i < 9; i++) begin
            rv = {7{16'h1F3C ^ (16'(i) * 16'h2B61)}};
            @(posedge clock);
            #1 ring_pins = rv[108:0];
            load_ir(rows[i].op);
            if (rows[i].len == 32) begin
                cap = 128'(ID);
            end else if (rows[i].len == 109) begin
                cap = 128'(rv[108:0]);
            end else begin
                cap = '0;
            end
            read_dr(rows[i].len, cap);
        end
        // Mode select alone brings back the idcode instruction
        load_ir(sbt_pkg::OP_BYPASS);
        ctl.run(1'b1, 5);
        ctl.run(1'b0, 1);
        read_dr(sbt_pkg::ID_W, 128'(ID));
        // Power-up reset with the test clock stopped in Shift-DR, so the output is driven when it hits
        load_ir(sbt_pkg::OP_BYPASS);
        ctl.step(1'b1, 1'b0, so, se);
        ctl.step(1'b0, 1'b0, so, se);
        ctl.step(1'b0, 1'b0, so, se);
        check(128'(tdo_oe_n), 128'h0);
        @(posedge clock);
        #1 reset = 1'b1;
        repeat (6) @(posedge clock);
        #1 reset = 1'b0;
        check(128'(tdo_oe_n), 128'h1);
        ctl.run(1'b0, 3);
        read_dr(sbt_pkg::ID_W, 128'(ID));
        tally_and_finish();
    end
endmodule

`default_nettype wire
